// ==== src/psp_cfg_array.sv ====
module psp_cfg_array
(
  // Clocking
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Array port
  psp_cfg_if.mem cfg
);
  logic [psp_pkg::CFG_BITS-1:0] mem_r [psp_pkg::CFG_WORDS];
  logic [psp_pkg::CFG_BITS-1:0] sum_v;

  // Storage; erase clears every word at once, writes fill by index
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < int'(psp_pkg::CFG_WORDS); i++)
        mem_r[i] <= psp_pkg::CFG_ERASED;
    end
    else if (ce)
    begin
      if (cfg.erase)
      begin
        for (int i = 0; i < int'(psp_pkg::CFG_WORDS); i++)
          mem_r[i] <= psp_pkg::CFG_ERASED;
      end
      else if (cfg.wr_en)
        mem_r[cfg.addr] <= cfg.wdata;
    end
  end

  // Pattern sum over all words, modulo the word width
  always_comb
  begin
    sum_v = '0;
    for (int i = 0; i < int'(psp_pkg::CFG_WORDS); i++)
      sum_v = sum_v + mem_r[i];
  end

  assign cfg.rdata = mem_r[cfg.addr];
  assign cfg.sum = sum_v;
endmodule

// ==== src/psp_cfg_if.sv ====
interface psp_cfg_if;
  // ==========================================
  // Configuration array port
  logic wr_en;
  logic erase;
  logic [psp_pkg::CFG_AW-1:0] addr;
  logic [psp_pkg::CFG_BITS-1:0] wdata;
  logic [psp_pkg::CFG_BITS-1:0] rdata;
  logic [psp_pkg::CFG_BITS-1:0] sum;
  modport ctl (output wr_en, output erase, output addr, output wdata, input rdata, input sum);
  modport mem (input wr_en, input erase, input addr, input wdata, output rdata, output sum);
endinterface

// ==== src/psp_pkg.sv ====
package psp_pkg;
  // ==========================================
  // Widths
  localparam int unsigned ID_BITS = 40;
  localparam int unsigned CFG_BITS = 32;
  localparam int unsigned CFG_WORDS = 16;
  localparam int unsigned CFG_AW = 4;
  localparam int unsigned NUM_REGS = 10;
  // ==========================================
  // Reset values
  localparam logic [ID_BITS-1:0] ID_RST = 40'h00_0000_0000;
  localparam logic [CFG_BITS-1:0] CFG_ERASED = 32'h0000_0000;
  localparam logic [15:0] CSUM_RST = 16'h0000;
  localparam logic [NUM_REGS-1:0] MC_RST = 10'h000;
  // ==========================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned POWER_ON_CLEAR_INTERVAL_NS = 1000;
  // Longest time rounds down, never below one cycle
  localparam int unsigned POR_CYCLES =
    (POWER_ON_CLEAR_INTERVAL_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (POWER_ON_CLEAR_INTERVAL_NS / CLK_PERIOD_NS);
  localparam int unsigned POR_CW = 5;
  localparam logic [POR_CW-1:0] POR_LAST = POR_CW'(POR_CYCLES - 1);
  // ==========================================
  // Programmer commands
  typedef enum logic [2:0]
  {
    PSP_CMD_NOP = 3'h0,
    PSP_CMD_PROG = 3'h1,
    PSP_CMD_READ = 3'h2,
    PSP_CMD_ID_WR = 3'h3,
    PSP_CMD_ID_RD = 3'h4,
    PSP_CMD_SECURE = 3'h5,
    PSP_CMD_CSUM = 3'h6
  } psp_cmd_e;
endpackage

// ==== src/psp_top.sv ====
// Behaviour
// R1: A 40-bit user identification word is held and freely writable by the programmer.
// R2: The identification word reads back regardless of the security cell.
// R3: Any nonzero identification bit changes the device checksum.
// R4: Once the security cell is set, pattern readback is refused.
// R5: Only a full programming cycle clears the security cell; here rst also clears secure_r.
// R6: Each programming cycle erases the array itself, no separate erase.
// R7: Undriven inputs and I/O pins read as logic one.
// R8: At power-up all registers clear low within the power-on clear interval.
// R9: After power-up reset, enabled registered output pins are high.
// R10: The board keeps the clock static during power-up; the bench clock toggles every 20 ns throughout reset.
// R11: The board sends no clock edge before the reset interval and setup are met; the bench clocks through reset and the window, and por_r holds reg_pin_o.
// R12: Registered outputs keep their reset level until the first valid clock edge loads data.
module psp_top
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Programmer command port
  input wire logic cmd_valid,
  input wire psp_pkg::psp_cmd_e cmd,
  input wire logic [psp_pkg::CFG_AW-1:0] cmd_addr,
  input wire logic [psp_pkg::CFG_BITS-1:0] cmd_wdata,
  input wire logic [psp_pkg::ID_BITS-1:0] cmd_id,
  output logic rsp_valid,
  output logic rsp_refused,
  output logic [psp_pkg::CFG_BITS-1:0] rsp_data,
  output logic [psp_pkg::ID_BITS-1:0] id_word,
  output logic secured,
  output logic [15:0] checksum,
  // User pins
  input wire logic [psp_pkg::NUM_REGS-1:0] pin_in,
  input wire logic [psp_pkg::NUM_REGS-1:0] pin_in_driven,
  input wire logic [psp_pkg::NUM_REGS-1:0] reg_d,
  input wire logic [psp_pkg::NUM_REGS-1:0] out_en,
  output logic [psp_pkg::NUM_REGS-1:0] pin_seen,
  output logic [psp_pkg::NUM_REGS-1:0] reg_pin_o,
  output logic [psp_pkg::NUM_REGS-1:0] reg_pin_oe,
  output logic por_busy
);
  // ==========================================
  // Programming sequencer
  typedef enum logic [2:0]
  {
    PSP_ST_IDLE = 3'h1,
    PSP_ST_ERASE = 3'h2,
    PSP_ST_WRITE = 3'h4
  } psp_st_e;

  psp_cfg_if cfg ();
  psp_st_e st_r;
  logic [psp_pkg::ID_BITS-1:0] id_r;
  logic secure_r;
  logic [psp_pkg::CFG_AW-1:0] addr_r;
  logic [psp_pkg::CFG_BITS-1:0] wdata_r;
  logic [psp_pkg::POR_CW-1:0] por_cnt_r;
  logic por_r;
  logic [15:0] csum_nxt;
  logic take;

  assign take = cmd_valid && st_r == PSP_ST_IDLE && !por_r;

  // Array port is driven from the sequencer
  assign cfg.erase = st_r == PSP_ST_ERASE; // R6
  assign cfg.wr_en = st_r == PSP_ST_WRITE;
  assign cfg.addr = take ? cmd_addr : addr_r;
  assign cfg.wdata = wdata_r;

  psp_cfg_array u_array
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .cfg(cfg)
  );

  // ==========================================
  // Power-on clear timer
  // Reset restarts the window; the board must keep clock edges from loading data meanwhile
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      por_cnt_r <= '0;
      por_r <= 1'b1;
    end
    else if (ce && por_r)
    begin
      if (por_cnt_r == psp_pkg::POR_LAST) // R8
        por_r <= 1'b0;
      else
        por_cnt_r <= por_cnt_r + 1'b1;
    end
  end

  // Sequencer: a programming command erases first, then writes one word
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r <= PSP_ST_IDLE;
      addr_r <= '0;
      wdata_r <= psp_pkg::CFG_ERASED;
    end
    else if (ce)
    begin
      case (st_r)
        PSP_ST_IDLE:
        begin
          if (take && cmd == psp_pkg::PSP_CMD_PROG)
          begin
            addr_r <= cmd_addr;
            wdata_r <= cmd_wdata;
            st_r <= PSP_ST_ERASE; // R6
          end
        end
        PSP_ST_ERASE: st_r <= PSP_ST_WRITE;
        PSP_ST_WRITE: st_r <= PSP_ST_IDLE;
        default: st_r <= PSP_ST_IDLE;
      endcase
    end
  end

  // Identification word, writable whenever the sequencer is idle, outside power-up
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      id_r <= psp_pkg::ID_RST;
    else if (ce && take && cmd == psp_pkg::PSP_CMD_ID_WR)
      id_r <= cmd_id; // R1
  end

  // Security cell: set by command, cleared by full reprogramming or by rst
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      secure_r <= 1'b0;
    else if (ce)
    begin
      if (take && cmd == psp_pkg::PSP_CMD_SECURE)
        secure_r <= 1'b1;
      else if (st_r == PSP_ST_ERASE)
        secure_r <= 1'b0; // R5
    end
  end

  // Checksum folds pattern sum and every ID byte, so nonzero ID bits show up
  always_comb
  begin
    csum_nxt = cfg.sum[15:0] + cfg.sum[31:16];
    for (int b = 0; b < int'(psp_pkg::ID_BITS / 8); b++)
      csum_nxt = csum_nxt + {8'h00, id_r[b*8 +: 8]}; // R3
  end

  // Command answers, one cycle after acceptance
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_refused <= 1'b0;
      rsp_data <= '0;
    end
    else if (ce)
    begin
      rsp_valid <= take && cmd != psp_pkg::PSP_CMD_NOP;
      rsp_refused <= 1'b0;
      rsp_data <= '0;
      if (take && cmd == psp_pkg::PSP_CMD_READ)
      begin
        if (secure_r)
          rsp_refused <= 1'b1; // R4
        else
          rsp_data <= cfg.rdata;
      end
    end
  end

  // Status mirrors: ID is readable regardless of the security cell
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      id_word <= psp_pkg::ID_RST;
      secured <= 1'b0;
      checksum <= psp_pkg::CSUM_RST;
      por_busy <= 1'b1;
    end
    else if (ce)
    begin
      id_word <= id_r; // R2
      secured <= secure_r;
      checksum <= csum_nxt;
      por_busy <= por_r;
    end
  end

  // ==========================================
  // Pins and macrocell registers
  // Pull-up: an undriven pin is seen as one
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pin_seen <= '1;
    else if (ce)
      pin_seen <= pin_in | ~pin_in_driven; // R7
  end

  // Registered pins hold the inverted register, so a register cleared low during
  // power-up shows a high pin; nothing loads until a clock edge past the window
  always_ff @(posedge ref_clk)
  begin
    if (rst || por_r)
      reg_pin_o <= ~psp_pkg::MC_RST; // R8 R9
    else if (ce)
      reg_pin_o <= ~reg_d; // R12
  end

  // Output enables follow their product terms one cycle late
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      reg_pin_oe <= '0;
    else if (ce)
      reg_pin_oe <= out_en;
  end
endmodule

// ==== verif/psp_board.sv ====
module psp_board
(
  // Clock
  input wire logic ref_clk,
  // Bench request
  input wire logic [psp_pkg::NUM_REGS-1:0] drive_mask,
  input wire logic [psp_pkg::NUM_REGS-1:0] drive_level,
  // Pins toward the device
  output logic [psp_pkg::NUM_REGS-1:0] pin_in,
  output logic [psp_pkg::NUM_REGS-1:0] pin_in_driven
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [psp_pkg::NUM_REGS-1:0] last_r = '0;
  // ==========================================
  // Released pins toggle, so only the device pull-up can make them read high
  assign pin_in = (drive_mask & drive_level) | (~drive_mask & ~last_r);
  assign pin_in_driven = drive_mask;
  // Remember the last level on every pin; plain always, as the variable starts known
  always @(posedge ref_clk)
  begin
    last_r <= pin_in;
  end
endmodule

// ==== verif/psp_top_sva.sv ====
module psp_top_sva
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched ports
  input wire psp_pkg::psp_cmd_e cmd,
  input wire logic [psp_pkg::ID_BITS-1:0] cmd_id,
  input wire logic rsp_valid,
  input wire logic rsp_refused,
  input wire logic [psp_pkg::CFG_BITS-1:0] rsp_data,
  input wire logic [psp_pkg::ID_BITS-1:0] id_word,
  input wire logic secured,
  input wire logic [psp_pkg::NUM_REGS-1:0] pin_in,
  input wire logic [psp_pkg::NUM_REGS-1:0] pin_in_driven,
  input wire logic [psp_pkg::NUM_REGS-1:0] pin_seen,
  input wire logic [psp_pkg::NUM_REGS-1:0] reg_pin_o,
  input wire logic por_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Checks; ce is held high by the bench
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_pin_pullup: assert property (!$past(rst) |->
    pin_seen == ($past(pin_in) | ~$past(pin_in_driven))) else $error("pin pull-up");
  a_read_refused: assert property (rsp_refused |->
    rsp_valid && rsp_data == '0 && secured) else $error("refused read");
  a_secure_sets: assert property (rsp_valid &&
    $past(cmd) == psp_pkg::PSP_CMD_SECURE |=> secured) else $error("secure set");
  a_secure_clear: assert property ($fell(secured) |->
    $past(cmd, 2) == psp_pkg::PSP_CMD_PROG || $past(cmd, 3) == psp_pkg::PSP_CMD_PROG)
    else $error("secure cleared");
  a_id_loads: assert property (rsp_valid &&
    $past(cmd) == psp_pkg::PSP_CMD_ID_WR |=> id_word == $past(cmd_id, 2)) else $error("id load");
  a_id_holds: assert property (!$past(rst) &&
    !(rsp_valid && $past(cmd) == psp_pkg::PSP_CMD_ID_WR) |=> $stable(id_word))
    else $error("id changed");
  a_por_bound: assert property ($fell(rst) |-> ##[0:26] !por_busy)
    else $error("power-on window");
  a_por_pins: assert property (por_busy |-> reg_pin_o == '1) else $error("pin low");
endmodule

bind psp_top psp_top_sva psp_top_sva_inst (.ref_clk, .rst, .cmd, .cmd_id, .rsp_valid,
  .rsp_refused, .rsp_data, .id_word, .secured, .pin_in, .pin_in_driven, .pin_seen,
  .reg_pin_o, .por_busy);

// ==== verif/tb_psp_top.sv ====
module tb_psp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst = 1, ce = 1, cmd_valid = 0, rsp_valid, rsp_refused, refd;
  psp_pkg::psp_cmd_e cmd = psp_pkg::PSP_CMD_NOP;
  logic [3:0] cmd_addr = '0;
  logic [31:0] cmd_wdata = '0, rsp_data, rd;
  logic [39:0] cmd_id = '0, id_word;
  logic secured, por_busy;
  logic [15:0] checksum;
  logic [9:0] pin_in, pin_in_driven, pin_seen, reg_pin_o, reg_pin_oe;
  logic [9:0] reg_d = '0, out_en = '0, mask = '0, lvl = '0;
  int err_count = 0, tests_run = 0;
  // ==========================================
  // Clock, device and board
  always #20 ref_clk = ~ref_clk;
  psp_top psp_top_inst (.ref_clk, .rst, .ce, .cmd_valid, .cmd, .cmd_addr, .cmd_wdata, .cmd_id,
    .rsp_valid, .rsp_refused, .rsp_data, .id_word, .secured, .checksum, .pin_in,
    .pin_in_driven, .reg_d, .out_en, .pin_seen, .reg_pin_o, .reg_pin_oe, .por_busy);
  psp_board psp_board_inst (.ref_clk, .drive_mask(mask), .drive_level(lvl), .pin_in,
    .pin_in_driven);
  task automatic stop_test;
    $display("Errors %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One command; a long pause after keeps PROG spacing and lets status settle
  task automatic issue(input psp_pkg::psp_cmd_e c, input logic [3:0] a,
    input logic [31:0] d, input logic [39:0] i);
    int k;
    cmd_valid = 1;
    cmd = c;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_id = i;
    tick(1);
    cmd_valid = 0;
    cmd = psp_pkg::PSP_CMD_NOP;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 3)
    begin
      tick(1);
      k++;
    end
    check(rsp_valid, "no answer");
    if (rsp_valid !== 1'b1)
      stop_test;
    else
    begin
      rd = rsp_data;
      refd = rsp_refused;
      tick(4);
    end
  endtask
  task automatic t_por;
    int k;
    reg_d = '1;
    out_en = '1;
    k = 0;
    while (por_busy === 1'b1 && k < 30)
    begin
      check(reg_pin_o === '1, "pin low in window");
      tick(1);
      k++;
    end
    check(k > 0 && k <= 26, "window length");
    if (por_busy === 1'b1)
      stop_test;
    else
    begin
      tick(3);
      check(reg_pin_o === ~reg_d && reg_pin_oe === out_en, "pins after window");
    end
  endtask
  task automatic t_pins;
    mask = 10'h155;
    lvl = 10'h104;
    tick(2);
    check(pin_seen === 10'h3ae, "floating pin not high");
    mask = '1;
    lvl = '0;
    tick(2);
    check(pin_seen === '0, "driven pin wrong");
  endtask
  task automatic t_prog;
    issue(psp_pkg::PSP_CMD_PROG, 4'h3, 32'h1234_5678, '0);
    issue(psp_pkg::PSP_CMD_READ, 4'h3, '0, '0);
    check(rd === 32'h1234_5678 && refd === 1'b0, "readback");
    issue(psp_pkg::PSP_CMD_PROG, 4'h5, 32'h0001_0002, '0);
    issue(psp_pkg::PSP_CMD_READ, 4'h3, '0, '0);
    check(rd === '0, "old word kept");
    issue(psp_pkg::PSP_CMD_READ, 4'h5, '0, '0);
    check(rd === 32'h0001_0002 && checksum === 16'h0003, "word or sum");
    issue(psp_pkg::PSP_CMD_ID_WR, 4'h0, '0, 40'h80_0000_0100);
    check(id_word === 40'h80_0000_0100, "id word");
    check(checksum === 16'h0084, "id not in sum");
  endtask
  task automatic t_secure;
    issue(psp_pkg::PSP_CMD_SECURE, 4'h0, '0, '0);
    check(secured === 1'b1, "cell not set");
    issue(psp_pkg::PSP_CMD_READ, 4'h5, '0, '0);
    check(refd === 1'b1 && rd === '0, "secured read");
    issue(psp_pkg::PSP_CMD_ID_RD, 4'h0, '0, '0);
    check(refd === 1'b0 && id_word === 40'h80_0000_0100, "id hidden");
    issue(psp_pkg::PSP_CMD_PROG, 4'h5, 32'h0000_00ff, '0);
    issue(psp_pkg::PSP_CMD_READ, 4'h5, '0, '0);
    check(secured === 1'b0 && rd === 32'h0000_00ff, "cell kept");
    issue(psp_pkg::PSP_CMD_CSUM, 4'h0, '0, '0);
    check(rd === '0 && refd === 1'b0 && checksum === 16'h0180, "checksum");
  endtask
  // ==========================================
  // Main sequence; commands wait until the power-on window is over
  initial
  begin
    // Power-up: commands and data inputs stay static while reset holds; released pins toggle
    tick(16);
    rst = 0;
    t_por();
    t_pins();
    t_prog();
    t_secure();
    stop_test();
  end
endmodule
